// >>> design/rxpt_pkg.sv
package rxpt_pkg;

    // register addresses on the serial control port
    localparam logic [4:0] ADDR_MOD_SLEEP = 5'h03;
    localparam logic [4:0] ADDR_CHK_MIN   = 5'h04;
    localparam logic [4:0] ADDR_RATE_MAX  = 5'h05;

    // modulation_sleep_control fields
    localparam int MOD_SEL_BIT   = 7;
    localparam int SLEEP_MSB     = 6;
    localparam int SLEEP_LSB     = 2;
    localparam int SLEEP_EXT_BIT = 1;
    localparam int LIM_EXT_BIT   = 0;

    // bitcheck_min_limit_control and rate_max_limit_control fields
    localparam int CHK_MSB  = 7;
    localparam int CHK_LSB  = 6;
    localparam int RATE_MSB = 7;
    localparam int RATE_LSB = 6;
    localparam int LIM_MSB  = 5;
    localparam int LIM_LSB  = 0;

    // reset values: fsk, sleep 0, no extension; 3 bits, min 11; range 2, max 32
    localparam logic [7:0] RST_MOD_SLEEP = 8'h00;
    localparam logic [7:0] RST_CHK_MIN   = 8'h4b;
    localparam logic [7:0] RST_RATE_MAX  = 8'ha0;

    // base digital clock derived from the 200 MHz reference
    localparam int REF_CLK_PERIOD_NS   = 5;
    localparam int BASE_CLOCK_PERIOD_NS = 40;
    localparam int DCLK_CYCLES = (BASE_CLOCK_PERIOD_NS / REF_CLK_PERIOD_NS < 1) ? 1 :
                                 BASE_CLOCK_PERIOD_NS / REF_CLK_PERIOD_NS;
    localparam logic [3:0] DCLK_LAST = 4'(DCLK_CYCLES - 1);

    // timing figures in base clock periods
    localparam int         SLEEP_UNIT_SHIFT = 10;   // 1024 periods per sleep step
    localparam int         SLEEP_EXT_SHIFT  = 3;    // extension multiplies by 8
    localparam int         SLEEP_CNT_W      = 18;
    localparam logic [3:0] XDCLK_BASE_MAX   = 4'h8; // range 0 scale, halved per code
    localparam logic [7:0] FD_BIT_LAST      = 8'ha7; // 168 periods per bit

    // bits examined per bit check, per code
    localparam logic [3:0] CHK_BITS_0 = 4'h0;
    localparam logic [3:0] CHK_BITS_1 = 4'h3;
    localparam logic [3:0] CHK_BITS_2 = 4'h6;
    localparam logic [3:0] CHK_BITS_3 = 4'h9;

    typedef enum logic [2:0] {
        RXPT_MODE_IDLE      = 3'b000,
        RXPT_MODE_RX        = 3'b001,
        RXPT_MODE_TX        = 3'b010,
        RXPT_MODE_FD_MASTER = 3'b011,
        RXPT_MODE_FD_SLAVE  = 3'b100
    } rxpt_mode_t;

endpackage : rxpt_pkg

// >>> design/rxpt_chk_if.sv
`timescale 1ns/10ps
`default_nettype none
interface rxpt_chk_if;
    logic       xdclk_tick;
    logic       enable;
    logic       start;
    logic [3:0] n_bits;
    logic [5:0] lim_min;
    logic [5:0] lim_max;
    logic       ok;
    logic       fail;
    logic       busy;

    modport ctl (output xdclk_tick, enable, start, n_bits, lim_min, lim_max,
                 input  ok, fail, busy);
    modport chk (input  xdclk_tick, enable, start, n_bits, lim_min, lim_max,
                 output ok, fail, busy);
endinterface : rxpt_chk_if
`default_nettype wire

// >>> design/rxpt_bitcheck.sv
`timescale 1ns/10ps
`default_nettype none
module rxpt_bitcheck
    import rxpt_pkg::*;
(
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    // demodulated receive data pin
    input  wire logic rx_data_i,
    // control side
    rxpt_chk_if.chk   cif
);

    typedef struct packed {
        logic       s1;
        logic       s2;
        logic       prev;
        logic       active;
        logic       armed;
        logic [6:0] ivl;
        logic [3:0] bits;
        logic       ok;
        logic       fail;
    } rxpt_chk_t;

    rxpt_chk_t q, d;
    logic      edge_seen;
    logic [6:0] ivl_max;
    logic [6:0] ivl_min;

    assign edge_seen = q.s2 ^ q.prev;
    assign ivl_min   = {1'b0, cif.lim_min};
    assign ivl_max   = {1'b0, cif.lim_max} - 7'h01;

    always_comb begin
        d      = q;
        d.s1   = rx_data_i;
        d.s2   = q.s1;
        d.prev = q.s2;
        d.ok   = 1'b0;
        d.fail = 1'b0;
        if (!cif.enable) begin
            d.active = 1'b0;
        end else if (cif.start) begin
            if (cif.n_bits == 4'h0) begin
                d.ok     = 1'b1;
                d.active = 1'b0;
            end else begin
                d.active = 1'b1;
                d.armed  = 1'b0;
                d.ivl    = 7'h00;
                d.bits   = 4'h0;
            end
        end else if (q.active) begin
            if (edge_seen) begin
                d.ivl = 7'h00;
                if (!q.armed) begin
                    d.armed = 1'b1;
                end else if (q.ivl < ivl_min || q.ivl > ivl_max) begin
                    d.fail   = 1'b1;
                    d.active = 1'b0;
                end else begin
                    d.bits = q.bits + 4'h1;
                    if (q.bits + 4'h1 == cif.n_bits) begin
                        d.ok     = 1'b1;
                        d.active = 1'b0;
                    end
                end
            end else if (cif.xdclk_tick && q.armed) begin
                // interval would pass the upper bound on this tick: fail without waiting
                if (q.ivl >= ivl_max) begin
                    d.fail   = 1'b1;
                    d.active = 1'b0;
                end else begin
                    d.ivl = q.ivl + 7'h01;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign cif.ok   = q.ok;
    assign cif.fail = q.fail;
    assign cif.busy = q.active;

    sequence s_zero_start;
        cif.enable && cif.start && cif.n_bits == 4'h0;
    endsequence

    sequence s_short_edge;
        cif.enable && !cif.start && q.active && q.armed && edge_seen && q.ivl < ivl_min;
    endsequence

    AST_CHK_NONE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_zero_start |=> cif.ok && !cif.busy)
        else $error("zero-bit check did not pass at once");

    AST_CHK_SHORT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_short_edge |=> cif.fail && !cif.busy)
        else $error("short edge interval not failed");

    AST_CHK_LONG: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (cif.enable && !cif.start && q.active && q.armed && !edge_seen && cif.xdclk_tick &&
         q.ivl == ivl_max) |=> cif.fail && !cif.ok && !cif.busy)
        else $error("interval beyond upper bound kept the check alive");

    AST_CHK_EXCL: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (cif.ok || cif.fail) |-> !(cif.ok && cif.fail) && !cif.busy)
        else $error("check ended with both results or kept running");

endmodule : rxpt_bitcheck
`default_nettype wire

// >>> design/rxpt_timing_cfg.sv
`timescale 1ns/10ps
`default_nettype none
module rxpt_timing_cfg
    import rxpt_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    // register access from the serial control port
    input  wire logic [4:0] reg_addr_i,
    input  wire logic       reg_wr_en_i,
    input  wire logic       reg_rd_en_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    // operating mode and sequencing from the transceiver control
    input  wire rxpt_mode_t mode_i,
    input  wire logic       sleep_start_i,
    input  wire logic       bit_check_start_i,
    // demodulated receive data pin
    input  wire logic       rx_data_i,
    // derived controls and timing
    output logic            modulation_select_o,
    output logic            dclk_tick_o,
    output logic            xdclk_tick_o,
    output logic            fd_bit_tick_o,
    output logic            sleep_busy_o,
    output logic            sleep_done_o,
    // bit check results
    output logic            check_busy_o,
    output logic            check_ok_o,
    output logic            check_fail_o
);

    typedef struct packed {
        logic [7:0]             mod_sleep;
        logic [7:0]             chk_min;
        logic [7:0]             rate_max;
        logic [7:0]             rdata;
        logic [3:0]             dclk_cnt;
        logic                   dclk_tick;
        logic [4:0]             xd_cnt;
        logic                   xd_tick;
        logic [7:0]             fd_cnt;
        logic                   fd_tick;
        logic [SLEEP_CNT_W-1:0] sleep_cnt;
        logic                   sleep_busy;
        logic                   sleep_done;
        logic                   mod_sel;
    } rxpt_ctl_t;

    rxpt_ctl_t q, d;

    rxpt_chk_if cif ();

    logic                   mode_rx;
    logic                   mode_fd;
    logic                   chk_mode;
    logic                   limit_ext_eff;
    logic [1:0]             rate_code;
    logic [4:0]             xd_period;
    logic [14:0]            sleep_base;
    logic [SLEEP_CNT_W-1:0] sleep_load;
    logic [3:0]             chk_bits;

    assign mode_rx   = (mode_i == RXPT_MODE_RX);
    assign mode_fd   = (mode_i == RXPT_MODE_FD_MASTER) || (mode_i == RXPT_MODE_FD_SLAVE);
    assign chk_mode  = mode_rx || (mode_i == RXPT_MODE_FD_SLAVE);
    assign rate_code = q.rate_max[RATE_MSB:RATE_LSB];

    // extension only counts while receiving
    assign limit_ext_eff = q.mod_sleep[LIM_EXT_BIT] && mode_rx;
    assign xd_period     = {1'b0, XDCLK_BASE_MAX >> rate_code} << limit_ext_eff;

    assign sleep_base = {q.mod_sleep[SLEEP_MSB:SLEEP_LSB], SLEEP_UNIT_SHIFT'(0)};
    assign sleep_load = q.mod_sleep[SLEEP_EXT_BIT] ?
                        {sleep_base, SLEEP_EXT_SHIFT'(0)} :
                        {SLEEP_EXT_SHIFT'(0), sleep_base};

    always_comb begin
        unique case (q.chk_min[CHK_MSB:CHK_LSB])
            2'b00: chk_bits = CHK_BITS_0;
            2'b01: chk_bits = CHK_BITS_1;
            2'b10: chk_bits = CHK_BITS_2;
            2'b11: chk_bits = CHK_BITS_3;
        endcase
    end

    always_comb begin
        d            = q;
        d.dclk_tick  = 1'b0;
        d.xd_tick    = 1'b0;
        d.fd_tick    = 1'b0;
        d.sleep_done = 1'b0;

        // register writes and reads
        if (reg_wr_en_i) begin
            unique case (reg_addr_i)
                ADDR_MOD_SLEEP: d.mod_sleep = reg_wdata_i;
                ADDR_CHK_MIN:   d.chk_min   = reg_wdata_i;
                ADDR_RATE_MAX:  d.rate_max  = reg_wdata_i;
                default:        ;
            endcase
        end
        if (reg_rd_en_i) begin
            unique case (reg_addr_i)
                ADDR_MOD_SLEEP: d.rdata = q.mod_sleep;
                ADDR_CHK_MIN:   d.rdata = q.chk_min;
                ADDR_RATE_MAX:  d.rdata = q.rate_max;
                default:        d.rdata = 8'h00;
            endcase
        end

        // modulation only acts in transmit and receive
        if (mode_i == RXPT_MODE_RX || mode_i == RXPT_MODE_TX) begin
            d.mod_sel = q.mod_sleep[MOD_SEL_BIT];
        end else begin
            d.mod_sel = 1'b0;
        end

        // base clock divider
        if (q.dclk_cnt >= DCLK_LAST) begin
            d.dclk_cnt  = 4'h0;
            d.dclk_tick = 1'b1;
        end else begin
            d.dclk_cnt = q.dclk_cnt + 4'h1;
        end

        // scaled timing clock; >= absorbs a period change mid-count
        if (q.dclk_tick) begin
            if (q.xd_cnt >= xd_period - 5'h01) begin
                d.xd_cnt  = 5'h00;
                d.xd_tick = 1'b1;
            end else begin
                d.xd_cnt = q.xd_cnt + 5'h01;
            end
        end

        // full-duplex bit clock in range 1
        if (mode_fd && rate_code == 2'b01) begin
            if (q.dclk_tick) begin
                if (q.fd_cnt >= FD_BIT_LAST) begin
                    d.fd_cnt  = 8'h00;
                    d.fd_tick = 1'b1;
                end else begin
                    d.fd_cnt = q.fd_cnt + 8'h01;
                end
            end
        end else begin
            d.fd_cnt = 8'h00;
        end

        // polling sleep timer, receive mode only
        if (!mode_rx) begin
            d.sleep_busy = 1'b0;
        end else if (sleep_start_i && !q.sleep_busy) begin
            if (sleep_load == '0) begin
                d.sleep_done = 1'b1;
            end else begin
                d.sleep_busy = 1'b1;
                d.sleep_cnt  = sleep_load;
            end
        end else if (q.sleep_busy && q.dclk_tick) begin
            d.sleep_cnt = q.sleep_cnt - SLEEP_CNT_W'(1);
            if (q.sleep_cnt == SLEEP_CNT_W'(1)) begin
                d.sleep_busy = 1'b0;
                d.sleep_done = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q           <= '0;
            q.mod_sleep <= RST_MOD_SLEEP;
            q.chk_min   <= RST_CHK_MIN;
            q.rate_max  <= RST_RATE_MAX;
        end else begin
            q <= d;
        end
    end

    // bit check, active in receive and full-duplex slave only
    assign cif.xdclk_tick = q.xd_tick;
    assign cif.enable     = chk_mode;
    assign cif.start      = bit_check_start_i && chk_mode;
    assign cif.n_bits     = chk_bits;
    assign cif.lim_min    = q.chk_min[LIM_MSB:LIM_LSB];
    assign cif.lim_max    = q.rate_max[LIM_MSB:LIM_LSB];

    rxpt_bitcheck u_bitcheck (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .rx_data_i (rx_data_i),
        .cif       (cif.chk)
    );

    assign reg_rdata_o         = q.rdata;
    assign modulation_select_o = q.mod_sel;
    assign dclk_tick_o         = q.dclk_tick;
    assign xdclk_tick_o        = q.xd_tick;
    assign fd_bit_tick_o       = q.fd_tick;
    assign sleep_busy_o        = q.sleep_busy;
    assign sleep_done_o        = q.sleep_done;
    assign check_busy_o        = cif.busy;
    assign check_ok_o          = cif.ok;
    assign check_fail_o        = cif.fail;

    // assertion helpers: base ticks between scaled ticks, fd ticks, sleep ticks
    logic [4:0]             ast_xd_gap;
    logic [4:0]             ast_xd_per;
    logic [7:0]             ast_fd_gap;
    logic [SLEEP_CNT_W-1:0] ast_sl_gap;
    logic [SLEEP_CNT_W-1:0] ast_sl_exp;
    logic                   ast_xd_chg;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ast_xd_gap <= 5'h00;
            ast_xd_per <= 5'h00;
            ast_fd_gap <= 8'h00;
            ast_sl_gap <= '0;
            ast_sl_exp <= '0;
            ast_xd_chg <= 1'b0;
        end else begin
            ast_xd_per <= xd_period;
            // period moved since the last scaled tick
            if (q.xd_tick) begin
                ast_xd_chg <= 1'b0;
            end else if (xd_period != ast_xd_per) begin
                ast_xd_chg <= 1'b1;
            end
            if (q.xd_tick) begin
                ast_xd_gap <= 5'h00;
            end else if (q.dclk_tick) begin
                ast_xd_gap <= ast_xd_gap + 5'h01;
            end
            if (q.fd_tick || !(mode_fd && rate_code == 2'b01)) begin
                ast_fd_gap <= 8'h00;
            end else if (q.dclk_tick) begin
                ast_fd_gap <= ast_fd_gap + 8'h01;
            end
            if (sleep_start_i && !q.sleep_busy) begin
                ast_sl_gap <= '0;
                ast_sl_exp <= sleep_load;
            end else if (q.sleep_busy && q.dclk_tick) begin
                ast_sl_gap <= ast_sl_gap + SLEEP_CNT_W'(1);
            end
        end
    end

    sequence s_sleep_run_end;
        q.sleep_busy && mode_rx ##1 q.sleep_done;
    endsequence

    AST_MOD_SEL: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (mode_i == RXPT_MODE_TX) |=> modulation_select_o == $past(q.mod_sleep[MOD_SEL_BIT]))
        else $error("modulation output does not follow the select bit");

    AST_MOD_FD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        mode_fd |=> !modulation_select_o)
        else $error("modulation select acted in full duplex");

    AST_XD_GAP: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (q.xd_tick && !ast_xd_chg) |-> ast_xd_gap == ast_xd_per)
        else $error("scaled tick spacing differs from the selected period");

    AST_XD_PER: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (q.dclk_tick && ast_xd_gap == ast_xd_per - 5'h01 && $stable(ast_xd_per) &&
         q.xd_cnt == ast_xd_gap) |=> q.xd_tick)
        else $error("scaled tick period wrong");

    AST_FD_RATE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (q.fd_tick && mode_fd && rate_code == 2'b01 && $past(ast_fd_gap) != 8'h00)
        |-> $past(ast_fd_gap) == FD_BIT_LAST)
        else $error("full duplex bit period not 168 base periods");

    AST_SLEEP_LEN: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_sleep_run_end |-> $past(ast_sl_gap) + SLEEP_CNT_W'(1) == ast_sl_exp)
        else $error("sleep time does not match count and extension");

    AST_SLEEP_IGN: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (!mode_rx && sleep_start_i) |=> !q.sleep_busy && !q.sleep_done)
        else $error("sleep started outside receive mode");

    AST_CHK_IGN: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !chk_mode |=> !check_busy_o && !check_ok_o)
        else $error("bit check ran outside receive or slave mode");

endmodule : rxpt_timing_cfg
`default_nettype wire

// >>> tb/rxpt_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module rxpt_host_model (
    // clock
    input  wire logic       ref_clk_i,
    // register port toward the device
    output logic      [4:0] reg_addr_o,
    output logic            reg_wr_en_o,
    output logic            reg_rd_en_o,
    output logic      [7:0] reg_wdata_o,
    input  wire logic [7:0] reg_rdata_i
);
    initial begin
        reg_addr_o  = 5'h00;
        reg_wr_en_o = 1'b0;
        reg_rd_en_o = 1'b0;
        reg_wdata_o = 8'h00;
    end

    // one-cycle strobe; address and data scrambled once released
    task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        reg_addr_o  = a;
        reg_wdata_o = d;
        reg_wr_en_o = 1'b1;
        @(negedge ref_clk_i);
        reg_wr_en_o = 1'b0;
        reg_addr_o  = ~a;
        reg_wdata_o = ~d;
    endtask : write_reg

    task automatic read_reg(input logic [4:0] a, output logic [7:0] d);
        @(negedge ref_clk_i);
        reg_addr_o  = a;
        reg_rd_en_o = 1'b1;
        @(negedge ref_clk_i);
        reg_rd_en_o = 1'b0;
        reg_addr_o  = ~a;
        @(negedge ref_clk_i);
        d = reg_rdata_i;
    endtask : read_reg
endmodule : rxpt_host_model
`default_nettype wire

// >>> tb/rx_polling_timing_config_tb.sv
`timescale 1ns/10ps
`default_nettype none
module rx_polling_timing_config_tb;
    import rxpt_pkg::*;
    logic       ref_clk_i;
    logic       rst_n_i;
    logic [4:0] reg_addr;
    logic       reg_wr_en;
    logic       reg_rd_en;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    rxpt_mode_t mode;
    logic       sleep_start;
    logic       chk_start;
    logic       rx_data;
    logic       mod_sel, dclk_tick, xdclk_tick, fd_tick, sleep_busy, sleep_done;
    logic       chk_busy, chk_ok, chk_fail, seen_ok, seen_fail;
    logic [7:0] rd, v3, v4, v5;
    int         failures, n_compared, seed, cyc;

    rxpt_host_model u_host (.ref_clk_i(ref_clk_i), .reg_addr_o(reg_addr),
        .reg_wr_en_o(reg_wr_en), .reg_rd_en_o(reg_rd_en), .reg_wdata_o(reg_wdata),
        .reg_rdata_i(reg_rdata));

    rxpt_timing_cfg dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr),
        .reg_wr_en_i(reg_wr_en), .reg_rd_en_i(reg_rd_en), .reg_wdata_i(reg_wdata),
        .reg_rdata_o(reg_rdata), .mode_i(mode), .sleep_start_i(sleep_start),
        .bit_check_start_i(chk_start), .rx_data_i(rx_data), .modulation_select_o(mod_sel),
        .dclk_tick_o(dclk_tick), .xdclk_tick_o(xdclk_tick), .fd_bit_tick_o(fd_tick),
        .sleep_busy_o(sleep_busy), .sleep_done_o(sleep_done), .check_busy_o(chk_busy),
        .check_ok_o(chk_ok), .check_fail_o(chk_fail));

    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    // result pulses last one cycle; keep them sticky for the tasks
    always @(negedge ref_clk_i) begin
        if (chk_ok === 1'b1) seen_ok = 1'b1;
        if (chk_fail === 1'b1) seen_fail = 1'b1;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    function automatic logic pick(input int s);
        return (s == 0) ? dclk_tick : (s == 1) ? xdclk_tick : fd_tick;
    endfunction : pick

    function automatic int tick_len(input int r, input int x);
        return ((8 >> r) << x) * 8;
    endfunction : tick_len

    // cycles between two successive pulses of the chosen tick
    task automatic period(input int s, output int n);
        int t;
        t = 0;
        n = 0;
        while (pick(s) !== 1'b1 && t < 4000) begin
            @(negedge ref_clk_i);
            t++;
        end
        @(negedge ref_clk_i);
        while (pick(s) !== 1'b1 && n < 4000) begin
            @(negedge ref_clk_i);
            n++;
        end
        n++;
    endtask : period

    task automatic sleep_run(input logic [4:0] cnt, input logic x, input int exp);
        int n;
        n = 0;
        u_host.write_reg(ADDR_MOD_SLEEP, {1'b0, cnt, x, 1'b0});
        sleep_start = 1'b1;
        @(negedge ref_clk_i);
        sleep_start = 1'b0;
        while (sleep_done !== 1'b1 && n < exp + 64) begin
            @(negedge ref_clk_i);
            n++;
        end
        check("sleep length", 32'(n >= exp - 10 && n <= exp + 10), 32'h1);
    endtask : sleep_run

    // arm edge, good edges of 12..27 ticks, then optional last edge after 'last' ticks
    task automatic bit_run(input rxpt_mode_t m, input logic [1:0] code, input int good,
                           input int last, input logic exp_ok);
        int n;
        n = 0;
        u_host.write_reg(ADDR_CHK_MIN, {code, 6'd11});
        mode = m;
        seen_ok = 1'b0;
        seen_fail = 1'b0;
        chk_start = 1'b1;
        @(negedge ref_clk_i);
        chk_start = 1'b0;
        repeat (40) @(negedge ref_clk_i);
        check("check busy", chk_busy, code != 2'b00);
        rx_data = ~rx_data;
        for (int i = 0; i < good; i++) begin
            repeat (16 * (12 + ($random(seed) & 15))) @(negedge ref_clk_i);
            rx_data = ~rx_data;
        end
        if (last > 0) begin
            repeat (16 * last) @(negedge ref_clk_i);
            rx_data = ~rx_data;
        end
        while (!(seen_ok || seen_fail) && n < 1200) begin
            @(negedge ref_clk_i);
            n++;
        end
        check("check ok", seen_ok, exp_ok);
        check("check fail", seen_fail, !exp_ok);
        check("check idle", chk_busy, 1'b0);
    endtask : bit_run

    initial begin
        #490000;
        failures++;
        report_and_stop();
    end

    initial begin
        seed = 32'h2954;
        failures = 0;
        n_compared = 0;
        rst_n_i = 1'b0;
        mode = RXPT_MODE_IDLE;
        sleep_start = 1'b0;
        chk_start = 1'b0;
        rx_data = 1'b0;
        seen_ok = 1'b0;
        seen_fail = 1'b0;
        repeat (8) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        u_host.read_reg(ADDR_MOD_SLEEP, rd);
        check("reset addr3", rd, {1'b0, 5'd0, 1'b0, 1'b0});
        u_host.read_reg(ADDR_CHK_MIN, rd);
        check("reset addr4", rd, {2'b01, 6'd11});
        u_host.read_reg(ADDR_RATE_MAX, rd);
        check("reset addr5", rd, {2'b10, 6'd32});
        for (int i = 0; i < 6; i++) begin
            v3 = 8'($random(seed));
            v4 = 8'($random(seed));
            v5 = 8'($random(seed));
            if (v4[5:0] < 6'd10) v4[5:0] = 6'd10;
            if (v5[5:0] < 6'd12) v5[5:0] = 6'd12;
            if (v3[7] && v5[7:6] == 2'b11) v5[7:6] = 2'b10;
            u_host.write_reg(ADDR_MOD_SLEEP, v3);
            u_host.write_reg(ADDR_CHK_MIN, v4);
            u_host.write_reg(ADDR_RATE_MAX, v5);
            u_host.write_reg(5'h06, ~v3);
            u_host.read_reg(ADDR_MOD_SLEEP, rd);
            check("addr3", rd, v3);
            u_host.read_reg(ADDR_CHK_MIN, rd);
            check("addr4", rd, v4);
            u_host.read_reg(ADDR_RATE_MAX, rd);
            check("addr5", rd, v5);
            u_host.read_reg(5'h06, rd);
            check("unmapped", rd, 8'h00);
        end
        $display("test registers done");
        u_host.write_reg(ADDR_MOD_SLEEP, 8'h80);
        u_host.write_reg(ADDR_RATE_MAX, {2'b10, 6'd32});
        mode = RXPT_MODE_RX;
        repeat (3) @(negedge ref_clk_i);
        check("ask in rx", mod_sel, 1'b1);
        mode = RXPT_MODE_FD_SLAVE;
        repeat (3) @(negedge ref_clk_i);
        check("ask in fd", mod_sel, 1'b0);
        $display("test modulation done");
        mode = RXPT_MODE_RX;
        period(0, cyc);
        check("dclk period", cyc, 8);
        for (int x = 0; x < 2; x++) begin
            for (int r = 0; r < 4; r++) begin
                u_host.write_reg(ADDR_MOD_SLEEP, {7'h00, 1'(x)});
                u_host.write_reg(ADDR_RATE_MAX, {2'(r), 6'd32});
                period(1, cyc);
                period(1, cyc);
                check("xdclk period", cyc, tick_len(r, x));
            end
        end
        mode = RXPT_MODE_TX;
        period(1, cyc);
        period(1, cyc);
        check("xdclk tx", cyc, tick_len(3, 0));
        u_host.write_reg(ADDR_RATE_MAX, {2'b01, 6'd32});
        mode = RXPT_MODE_FD_MASTER;
        period(2, cyc);
        period(2, cyc);
        check("fd bit period", cyc, 168 * 8);
        $display("test ticks done");
        u_host.write_reg(ADDR_MOD_SLEEP, 8'h00);
        u_host.write_reg(ADDR_RATE_MAX, {2'b10, 6'd32});
        for (int c = 0; c < 4; c++) bit_run(RXPT_MODE_RX, 2'(c), 3 * c, 0, 1'b1);
        bit_run(RXPT_MODE_FD_SLAVE, 2'b01, 3, 0, 1'b1);
        bit_run(RXPT_MODE_RX, 2'b01, 1, 9, 1'b0);
        bit_run(RXPT_MODE_RX, 2'b01, 1, -1, 1'b0);
        $display("test bit check done");
        mode = RXPT_MODE_TX;
        sleep_start = 1'b1;
        @(negedge ref_clk_i);
        sleep_start = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        check("sleep in tx", sleep_busy, 1'b0);
        mode = RXPT_MODE_RX;
        sleep_run(5'd0, 1'b0, 1);
        sleep_run(5'd1, 1'b0, 1024 * 8);
        sleep_run(5'd1, 1'b1, 1024 * 8 * 8);
        $display("test sleep done");
        report_and_stop();
    end
endmodule : rx_polling_timing_config_tb
`default_nettype wire
